//--- wmb_pkg.sv
package wmb_pkg;

  // Clock and timing figures in their own units
  localparam longint unsigned CLK_HZ       = 64'd250_000_000;
  localparam longint unsigned RETRY_S      = 64'd60;
  localparam longint unsigned INACT_S      = 64'd300;
  localparam longint unsigned REFRESH_S    = 64'd120;
  localparam longint unsigned LED_SOLID_S  = 64'd2;
  localparam longint unsigned HEARTBEAT_S  = 64'd4;
  localparam longint unsigned DEBOUNCE_MS  = 64'd10;
  localparam longint unsigned BLINK_MS     = 64'd50;

  // Derived cycle counts at the reference clock
  localparam longint unsigned RETRY_CYC     = RETRY_S * CLK_HZ;
  localparam longint unsigned INACT_CYC     = INACT_S * CLK_HZ;
  localparam longint unsigned REFRESH_CYC   = REFRESH_S * CLK_HZ;
  localparam longint unsigned LED_SOLID_CYC = LED_SOLID_S * CLK_HZ;
  localparam longint unsigned HEARTBEAT_CYC = HEARTBEAT_S * CLK_HZ;
  localparam longint unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned BLINK_CYC     = BLINK_MS * CLK_HZ / 64'd1000;

  // Width of all long timers
  localparam int CNT_W = 40;

  // Hosted network client limit
  localparam logic [3:0] MAX_CLIENTS = 4'h8;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG      = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_STA_ADDR = 8'h08;
  localparam logic [7:0] OFS_GOT_ADDR = 8'h0c;

  // Configuration register fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_MSB = 2;
  localparam int CFG_PASS_BIT = 3;

  // Status register fields
  localparam int STS_STATE_LSB = 0;
  localparam int STS_STATE_MSB = 6;
  localparam int STS_PWR_BIT   = 7;
  localparam int STS_CLI_LSB   = 8;
  localparam int STS_CLI_MSB   = 11;
  localparam int STS_LLOC_BIT  = 12;
  localparam int STS_DHCP_BIT  = 13;

  // Operating modes
  localparam logic [2:0] MODE_JOIN        = 3'h0;
  localparam logic [2:0] MODE_CREATE      = 3'h1;
  localparam logic [2:0] MODE_OFF_JOIN    = 3'h2;
  localparam logic [2:0] MODE_OFF_CREATE  = 3'h3;
  localparam logic [2:0] MODE_JOIN_CREATE = 3'h4;
  localparam logic [2:0] MODE_DISABLED    = 3'h5;

  // Reset values
  localparam logic [2:0]  RST_MODE     = MODE_OFF_JOIN;
  localparam logic        RST_PASS     = 1'b0;
  localparam logic [31:0] RST_STA_ADDR = 32'h0000_0000;

  // Link-local prefix 169.254
  localparam logic [15:0] LINK_LOCAL_PFX = 16'ha9fe;

  // Controller states
  typedef enum logic [6:0] {
    ST_OFF       = 7'h01,
    ST_JOIN_TRY  = 7'h02,
    ST_JOINED    = 7'h04,
    ST_JOIN_WAIT = 7'h08,
    ST_HOST_TRY  = 7'h10,
    ST_HOSTING   = 7'h20,
    ST_HOST_WAIT = 7'h40
  } wmb_state_t;

  // Commands toward the radio module
  typedef struct packed {
    logic power_en;
    logic low_power;
    logic join_req;
    logic host_req;
    logic host_secure;
    logic host_default_name;
    logic join_traffic_en;
    logic dhcp_en;
  } wmb_radio_ctl_t;

  // Events and status from the radio module
  typedef struct packed {
    logic        join_ok;
    logic        join_fail;
    logic        host_ok;
    logic        host_fail;
    logic        tx_evt;
    logic        rx_evt;
    logic        client_join;
    logic        client_leave;
    logic [31:0] got_addr;
  } wmb_radio_sts_t;

endpackage : wmb_pkg

//--- wmb_ctrl.sv
`timescale 1ns/10ps
module wmb_ctrl #(
  parameter longint unsigned RETRY_CYC     = wmb_pkg::RETRY_CYC,
  parameter longint unsigned INACT_CYC     = wmb_pkg::INACT_CYC,
  parameter longint unsigned REFRESH_CYC   = wmb_pkg::REFRESH_CYC,
  parameter longint unsigned LED_SOLID_CYC = wmb_pkg::LED_SOLID_CYC,
  parameter longint unsigned HEARTBEAT_CYC = wmb_pkg::HEARTBEAT_CYC,
  parameter longint unsigned DEBOUNCE_CYC  = wmb_pkg::DEBOUNCE_CYC,
  parameter longint unsigned BLINK_CYC     = wmb_pkg::BLINK_CYC
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Radio module
  output wmb_pkg::wmb_radio_ctl_t      radio_ctl,
  input  wire wmb_pkg::wmb_radio_sts_t radio_sts,
  output logic                         client_accept,
  // Board
  input  wire logic                    power_ok,
  input  wire logic                    button_n,
  output logic                         led_green,
  output logic                         led_red
);

  localparam int CW = wmb_pkg::CNT_W;

  wmb_pkg::wmb_state_t state_reg;
  wmb_pkg::wmb_state_t state_next;

  logic [2:0]    mode_reg;
  logic          pass_reg;
  logic [31:0]   sta_addr_reg;
  logic          ack_reg;
  logic [31:0]   dat_reg;
  logic          bus_req;
  logic          wr_cfg;

  logic          btn_stable_reg;
  logic [CW-1:0] deb_reg;
  logic          press_evt;

  logic [CW-1:0] tmo_reg;
  logic          tmo_active;
  logic          tmo_expire;
  logic          tmo_refresh;
  logic          wake_evt;
  logic [CW-1:0] retry_reg;
  logic [3:0]    clients_reg;

  logic [CW-1:0] hold_reg;
  logic [CW-1:0] beat_reg;
  logic [CW-1:0] blink_reg;
  logic          led_green_reg;
  logic          led_red_reg;

  logic          btn_mode;
  logic          off_mode;
  logic          temp_host;
  logic          in_host;
  logic          connected;
  logic          entering_try;

  // Mode classification
  assign off_mode = (mode_reg == wmb_pkg::MODE_OFF_JOIN) ||
                    (mode_reg == wmb_pkg::MODE_OFF_CREATE);
  assign btn_mode = off_mode || (mode_reg == wmb_pkg::MODE_JOIN_CREATE);
  assign in_host  = (state_reg == wmb_pkg::ST_HOST_TRY) ||
                    (state_reg == wmb_pkg::ST_HOSTING)  ||
                    (state_reg == wmb_pkg::ST_HOST_WAIT);
  assign temp_host = (mode_reg == wmb_pkg::MODE_JOIN_CREATE) && in_host;
  assign connected = (state_reg == wmb_pkg::ST_JOINED) ||
                     (state_reg == wmb_pkg::ST_HOSTING);

  // Wishbone request, answered one cycle later
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_cfg  = bus_req && wb_we_i && wb_sel_i[0] &&
                   (wb_adr_i == wmb_pkg::OFS_CFG);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // Configuration register, low byte only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_reg <= wmb_pkg::RST_MODE;
      pass_reg <= wmb_pkg::RST_PASS;
    end else if (wr_cfg) begin
      mode_reg <= wb_dat_i[wmb_pkg::CFG_MODE_MSB:wmb_pkg::CFG_MODE_LSB];
      pass_reg <= wb_dat_i[wmb_pkg::CFG_PASS_BIT];
    end
  end

  // Station address, one generate lane per byte enable
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          sta_addr_reg[gi*8 +: 8] <= wmb_pkg::RST_STA_ADDR[gi*8 +: 8];
        end else if (bus_req && wb_we_i && wb_sel_i[gi] &&
                     (wb_adr_i == wmb_pkg::OFS_STA_ADDR)) begin
          sta_addr_reg[gi*8 +: 8] <= wb_dat_i[gi*8 +: 8];
        end
      end
    end
  endgenerate

  // Read data; unmapped offsets answer zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dat_reg <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      dat_reg <= 32'h0000_0000;
      case (wb_adr_i)
        wmb_pkg::OFS_CFG: begin
          dat_reg[wmb_pkg::CFG_MODE_MSB:wmb_pkg::CFG_MODE_LSB] <= mode_reg;
          dat_reg[wmb_pkg::CFG_PASS_BIT] <= pass_reg;
        end
        wmb_pkg::OFS_STATUS: begin
          dat_reg[wmb_pkg::STS_STATE_MSB:wmb_pkg::STS_STATE_LSB] <= state_reg;
          dat_reg[wmb_pkg::STS_PWR_BIT] <= radio_ctl.power_en;
          dat_reg[wmb_pkg::STS_CLI_MSB:wmb_pkg::STS_CLI_LSB] <= clients_reg;
          dat_reg[wmb_pkg::STS_LLOC_BIT] <=
            (radio_sts.got_addr[31:16] == wmb_pkg::LINK_LOCAL_PFX);
          dat_reg[wmb_pkg::STS_DHCP_BIT] <= radio_ctl.dhcp_en;
        end
        wmb_pkg::OFS_STA_ADDR: dat_reg <= sta_addr_reg;
        wmb_pkg::OFS_GOT_ADDR: dat_reg <= radio_sts.got_addr;
        default:               dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      btn_stable_reg <= 1'b0;
      deb_reg        <= '0;
    end else if (btn_stable_reg == !button_n) begin
      deb_reg <= '0;
    end else if (deb_reg >= CW'(DEBOUNCE_CYC) - CW'(1)) begin
      btn_stable_reg <= !button_n;
      deb_reg        <= '0;
    end else begin
      deb_reg <= deb_reg + CW'(1);
    end
  end

  // One event per debounced press edge
  assign press_evt = !btn_stable_reg && !button_n &&
                     (deb_reg >= CW'(DEBOUNCE_CYC) - CW'(1)) && btn_mode;

  // Mode state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wmb_pkg::ST_OFF: begin
        if (mode_reg == wmb_pkg::MODE_JOIN ||
            mode_reg == wmb_pkg::MODE_JOIN_CREATE) begin
          state_next = wmb_pkg::ST_JOIN_TRY;
        end else if (mode_reg == wmb_pkg::MODE_CREATE) begin
          state_next = wmb_pkg::ST_HOST_TRY;
        end else if (press_evt && mode_reg == wmb_pkg::MODE_OFF_JOIN) begin
          state_next = wmb_pkg::ST_JOIN_TRY;
        end else if (press_evt && mode_reg == wmb_pkg::MODE_OFF_CREATE) begin
          state_next = wmb_pkg::ST_HOST_TRY;
        end
      end
      wmb_pkg::ST_JOIN_TRY: begin
        if (radio_sts.join_ok) begin
          state_next = wmb_pkg::ST_JOINED;
        end else if (radio_sts.join_fail) begin
          state_next = wmb_pkg::ST_JOIN_WAIT;
        end
      end
      wmb_pkg::ST_JOINED: begin
        if (radio_sts.join_fail) begin
          state_next = wmb_pkg::ST_JOIN_WAIT;
        end
      end
      wmb_pkg::ST_JOIN_WAIT: begin
        if (retry_reg == '0) begin
          state_next = wmb_pkg::ST_JOIN_TRY;
        end
      end
      wmb_pkg::ST_HOST_TRY: begin
        if (radio_sts.host_ok) begin
          state_next = wmb_pkg::ST_HOSTING;
        end else if (radio_sts.host_fail) begin
          state_next = wmb_pkg::ST_HOST_WAIT;
        end
      end
      wmb_pkg::ST_HOSTING: begin
        if (radio_sts.host_fail) begin
          state_next = wmb_pkg::ST_HOST_WAIT;
        end
      end
      wmb_pkg::ST_HOST_WAIT: begin
        if (retry_reg == '0) begin
          state_next = wmb_pkg::ST_HOST_TRY;
        end
      end
      default: state_next = wmb_pkg::ST_OFF;
    endcase
    // Button and timeout take precedence over radio events
    if (state_reg != wmb_pkg::ST_OFF) begin
      if (off_mode && (press_evt || tmo_expire)) begin
        state_next = wmb_pkg::ST_OFF;
      end else if (mode_reg == wmb_pkg::MODE_JOIN_CREATE) begin
        if (press_evt && !in_host) begin
          state_next = wmb_pkg::ST_HOST_TRY;
        end else if ((press_evt || tmo_expire) && in_host) begin
          state_next = wmb_pkg::ST_JOIN_TRY;
        end
      end
    end
    // disabled or reserved mode; a mode change restarts
    if (wr_cfg || !(off_mode || mode_reg == wmb_pkg::MODE_JOIN ||
                    mode_reg == wmb_pkg::MODE_CREATE ||
                    mode_reg == wmb_pkg::MODE_JOIN_CREATE)) begin
      state_next = wmb_pkg::ST_OFF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= wmb_pkg::ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Inactivity timer for button-started sessions
  assign wake_evt    = press_evt && ((off_mode && state_reg == wmb_pkg::ST_OFF) ||
                       (mode_reg == wmb_pkg::MODE_JOIN_CREATE && !in_host &&
                        state_reg != wmb_pkg::ST_OFF));
  assign tmo_active  = (off_mode && state_reg != wmb_pkg::ST_OFF) || temp_host;
  assign tmo_expire  = tmo_active && (tmo_reg == '0);
  assign tmo_refresh = off_mode ? radio_sts.tx_evt : radio_sts.rx_evt;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tmo_reg <= '0;
    end else if (wake_evt) begin
      tmo_reg <= CW'(INACT_CYC);
    end else if (tmo_active && tmo_refresh) begin
      tmo_reg <= tmo_reg + CW'(REFRESH_CYC) - CW'(1);
    end else if (tmo_active && tmo_reg != '0) begin
      tmo_reg <= tmo_reg - CW'(1);
    end
  end

  // Retry wait, loaded on entry to a wait state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      retry_reg <= '0;
    end else if ((state_next == wmb_pkg::ST_JOIN_WAIT ||
                  state_next == wmb_pkg::ST_HOST_WAIT) &&
                 state_next != state_reg) begin
      retry_reg <= CW'(RETRY_CYC) - CW'(1);
    end else if (retry_reg != '0) begin
      retry_reg <= retry_reg - CW'(1);
    end
  end

  // Client count; leave wins nothing over join, both net to zero
  assign client_accept = (state_reg == wmb_pkg::ST_HOSTING) &&
                         (clients_reg < wmb_pkg::MAX_CLIENTS);

  always_ff @(posedge ref_clk) begin
    if (reset || state_reg != wmb_pkg::ST_HOSTING) begin
      clients_reg <= 4'h0;
    end else begin
      case ({radio_sts.client_join && client_accept,
             radio_sts.client_leave && clients_reg != 4'h0})
        2'b10:   clients_reg <= clients_reg + 4'h1;
        2'b01:   clients_reg <= clients_reg - 4'h1;
        default: clients_reg <= clients_reg;
      endcase
    end
  end

  // Radio commands
  always_comb begin
    radio_ctl.power_en   = (state_reg != wmb_pkg::ST_OFF);
    radio_ctl.low_power  = (state_reg == wmb_pkg::ST_JOIN_WAIT) ||
                           (state_reg == wmb_pkg::ST_HOST_WAIT);
    radio_ctl.join_req   = (state_reg == wmb_pkg::ST_JOIN_TRY);
    radio_ctl.host_req   = (state_reg == wmb_pkg::ST_HOST_TRY);
    radio_ctl.host_secure       = pass_reg && !temp_host;
    radio_ctl.host_default_name = temp_host;
    radio_ctl.join_traffic_en   = (state_reg == wmb_pkg::ST_JOINED);
    radio_ctl.dhcp_en           = (sta_addr_reg == 32'h0000_0000);
  end

  // LED hold, heartbeat and blink timers
  assign entering_try = (state_next != state_reg) &&
                        (state_next == wmb_pkg::ST_JOIN_TRY ||
                         state_next == wmb_pkg::ST_HOST_TRY);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hold_reg <= '0;
    end else if (entering_try) begin
      hold_reg <= CW'(LED_SOLID_CYC) - CW'(1);
    end else if (hold_reg != '0) begin
      hold_reg <= hold_reg - CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || beat_reg == '0) begin
      beat_reg <= CW'(HEARTBEAT_CYC) - CW'(1);
    end else begin
      beat_reg <= beat_reg - CW'(1);
    end
  end

  // Blink restarts on traffic while joined or hosting, or on the four second beat
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      blink_reg <= '0;
    end else if (beat_reg == '0 ||
                 (connected && (radio_sts.tx_evt || radio_sts.rx_evt))) begin
      blink_reg <= CW'(BLINK_CYC);
    end else if (blink_reg != '0) begin
      blink_reg <= blink_reg - CW'(1);
    end
  end

  // LED colour; amber is both dies lit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      led_green_reg <= 1'b0;
      led_red_reg   <= 1'b0;
    end else if (!power_ok) begin
      led_green_reg <= 1'b0;
      led_red_reg   <= 1'b0;
    end else begin
      led_green_reg <= 1'b0;
      led_red_reg   <= 1'b0;
      case (state_reg)
        wmb_pkg::ST_JOIN_TRY: led_green_reg <= 1'b1;
        wmb_pkg::ST_JOINED: begin
          led_green_reg <= (hold_reg != '0) || (blink_reg != '0);
        end
        wmb_pkg::ST_JOIN_WAIT: led_red_reg <= (blink_reg != '0);
        wmb_pkg::ST_HOST_TRY: begin
          led_green_reg <= 1'b1;
          led_red_reg   <= 1'b1;
        end
        wmb_pkg::ST_HOSTING: begin
          led_green_reg <= (hold_reg != '0) || (blink_reg != '0);
          led_red_reg   <= (hold_reg != '0) || (blink_reg != '0);
        end
        // dark when off or host retry
        default: begin
          led_green_reg <= 1'b0;
          led_red_reg   <= 1'b0;
        end
      endcase
    end
  end

  assign led_green = led_green_reg;
  assign led_red   = led_red_reg;

endmodule : wmb_ctrl

//--- wmb_props.sv
`timescale 1ns/10ps
module wmb_props (
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    reset,
  // Bus handshake
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_ack_o,
  // Radio and board
  input wire wmb_pkg::wmb_radio_ctl_t radio_ctl,
  input wire logic                    client_accept,
  input wire logic                    power_ok,
  input wire logic                    led_green,
  input wire logic                    led_red
);
  // One domain, so one clock and one disable
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Solid colours right after an attempt starts
  sequence s_green;
    (led_green && !led_red) [*8];
  endsequence
  sequence s_amber;
    (led_green && led_red) [*8];
  endsequence

  // Bus answers one cycle after the request, for one cycle
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not one cycle after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_retry_wait;
    $rose(radio_ctl.low_power) |=>
      (radio_ctl.low_power && !radio_ctl.join_req) [*8];
  endproperty
  a_retry_wait: assert property (p_retry_wait)
    else $error("retry wait cut short");
  property p_clients;
    client_accept |-> radio_ctl.power_en;
  endproperty
  a_clients: assert property (p_clients)
    else $error("clients accepted with radio off");
  property p_open_net;
    radio_ctl.host_default_name |-> !radio_ctl.host_secure;
  endproperty
  a_open_net: assert property (p_open_net)
    else $error("temporary network is secured");
  property p_no_join_traffic;
    radio_ctl.host_req |-> !radio_ctl.join_traffic_en;
  endproperty
  a_no_join_traffic: assert property (p_no_join_traffic)
    else $error("joined traffic while hosting");
  property p_dark_off;
    !radio_ctl.power_en |=> !led_green && !led_red;
  endproperty
  a_dark_off: assert property (p_dark_off)
    else $error("LED lit with radio off");
  property p_dark_low;
    !power_ok |=> !led_green && !led_red;
  endproperty
  a_dark_low: assert property (p_dark_low)
    else $error("LED lit on low supply");
  property p_join_solid;
    $rose(radio_ctl.join_req) |=> s_green;
  endproperty
  a_join_solid: assert property (p_join_solid)
    else $error("join attempt not solid green");
  property p_host_solid;
    $rose(radio_ctl.host_req) |=> s_amber;
  endproperty
  a_host_solid: assert property (p_host_solid)
    else $error("host attempt not solid amber");
endmodule : wmb_props

bind wmb_ctrl wmb_props u_wmb_props (.ref_clk, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .radio_ctl, .client_accept, .power_ok,
  .led_green, .led_red);

//--- wmb_radio_model.sv
`timescale 1ns/10ps
module wmb_radio_model (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  // Radio side
  input  wire wmb_pkg::wmb_radio_ctl_t radio_ctl,
  output wmb_pkg::wmb_radio_sts_t      radio_sts,
  // Scenario control
  input  wire logic                    fail,
  input  wire logic [7:0]              dly,
  input  wire logic [3:0]              evt,
  input  wire logic [31:0]             addr
);
  logic [7:0] wait_reg;

  // One answer per attempt, dly+1 cycles after it starts
  always_ff @(posedge ref_clk) begin
    radio_sts <= '0;
    // Unpowered radio shows a scrambled address, never a stale one
    radio_sts.got_addr <= radio_ctl.power_en ? addr : ~addr;
    if (reset || !(radio_ctl.join_req || radio_ctl.host_req)) begin
      wait_reg <= dly;
    end else if (wait_reg != 8'h00) begin
      wait_reg <= wait_reg - 8'h01;
    end else begin
      wait_reg            <= 8'hff;
      radio_sts.join_ok   <= radio_ctl.join_req && !fail;
      radio_sts.join_fail <= radio_ctl.join_req && fail;
      radio_sts.host_ok   <= radio_ctl.host_req && !fail;
      radio_sts.host_fail <= radio_ctl.host_req && fail;
    end
    // Traffic and clients only reach an awake radio
    if (radio_ctl.power_en && !radio_ctl.low_power) begin
      {radio_sts.tx_evt, radio_sts.rx_evt, radio_sts.client_join,
       radio_sts.client_leave} <= evt;
    end
  end
endmodule : wmb_radio_model

//--- wmb_ctrl_tb_top.sv
`timescale 1ns/10ps
module wmb_ctrl_tb_top;
  logic                    ref_clk = 1'b0;
  logic                    reset   = 1'b1;
  logic                    cyc     = 1'b0;
  logic                    we      = 1'b0;
  logic [7:0]              adr     = 8'h00;
  logic [31:0]             wdat    = 32'h0;
  logic                    fail    = 1'b0;
  logic                    pwr_ok  = 1'b1;
  logic                    btn_n   = 1'b1;
  logic [3:0]              evt     = 4'h0;
  logic [3:0]              sel     = 4'hf;
  logic [7:0]              dly     = 8'h0c;
  logic [31:0]             addr    = 32'ha9fe0102;
  logic [31:0]             rdat, rd;
  logic                    ack, grn, red, acc, hit_g, hit_r;
  wmb_pkg::wmb_radio_ctl_t ctl;
  wmb_pkg::wmb_radio_sts_t sts;
  int                      err_count, comparisons, cyc_n;

  // Short timers so the run stays brief
  localparam longint unsigned T_RETRY = 200, T_INACT = 400, T_REFR = 100;
  localparam longint unsigned T_SOLID = 20, T_BEAT = 50, T_DEB = 4;
  localparam longint unsigned T_BLINK = 5;
  wmb_ctrl #(.RETRY_CYC(T_RETRY), .INACT_CYC(T_INACT), .REFRESH_CYC(T_REFR),
    .LED_SOLID_CYC(T_SOLID), .HEARTBEAT_CYC(T_BEAT), .DEBOUNCE_CYC(T_DEB),
    .BLINK_CYC(T_BLINK)) u_wmb_ctrl (.ref_clk, .reset, .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .radio_ctl(ctl),
    .radio_sts(sts), .client_accept(acc), .power_ok(pwr_ok),
    .button_n(btn_n), .led_green(grn), .led_red(red));
  wmb_radio_model u_wmb_radio_model (.ref_clk, .reset,
    .radio_ctl(ctl), .radio_sts(sts), .fail, .dly, .evt, .addr);

  always #2 ref_clk = ~ref_clk;

  // Hang guard
  always @(posedge ref_clk) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // Classic cycle: hold until ack, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wait_st(input logic [31:0] s);
    for (int i = 0; i < 400; i++) begin
      bus(1'b0, 8'h04, 32'h0);
      if ((rd & 32'h7f) === s) break;
    end
    chk(rd & 32'h7f, s);
  endtask : wait_st

  // Held well past the debounce both ways
  task automatic press;
    btn_n <= 1'b0;
    tick(8);
    btn_n <= 1'b1;
    tick(8);
  endtask : press

  task automatic watch(input int n);
    hit_g = 1'b0;
    hit_r = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      hit_g |= grn;
      hit_r |= red;
    end
  endtask : watch

  task automatic t_reset;
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h2);
    // Low byte lane off: mode write must be ignored
    sel <= 4'he;
    bus(1'b1, 8'h00, 32'h5);
    sel <= 4'hf;
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h2001);
    bus(1'b0, 8'hf0, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h08, 32'h0a000001);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h2000, 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_offjoin;
    press();
    chk(ctl.power_en, 1'b1);
    wait_st(32'h04);
    chk(rd & 32'h1000, 32'h1000);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'ha9fe0102);
    evt <= 4'h8;
    tick(1);
    evt <= 4'h0;
    watch(60);
    chk(hit_g, 1'b1);
    tick(320);
    chk(ctl.power_en, 1'b1);
    for (int i = 0; i < 200 && ctl.power_en; i++) tick(1);
    tick(2);
    chk({ctl.power_en, grn, red}, 32'h0);
    press();
    press();
    tick(2);
    chk({ctl.power_en, grn, red}, 32'h0);
    $display("t_offjoin done");
  endtask : t_offjoin

  task automatic t_join;
    fail <= 1'b1;
    bus(1'b1, 8'h00, 32'h0);
    wait_st(32'h08);
    chk(ctl.low_power, 1'b1);
    watch(120);
    chk(hit_r, 1'b1);
    chk(ctl.join_req, 1'b0);
    fail <= 1'b0;
    wait_st(32'h04);
    press();
    bus(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h7f, 32'h04);
    $display("t_join done");
  endtask : t_join

  task automatic t_create;
    bus(1'b1, 8'h00, 32'h9);
    tick(2);
    chk(ctl.host_secure, 1'b1);
    wait_st(32'h20);
    repeat (9) begin
      evt <= 4'h2;
      tick(1);
      evt <= 4'h0;
      tick(1);
    end
    bus(1'b0, 8'h04, 32'h0);
    chk(rd & 32'hf00, 32'h800);
    chk(acc, 1'b0);
    pwr_ok <= 1'b0;
    tick(3);
    chk({grn, red}, 32'h0);
    pwr_ok <= 1'b1;
    bus(1'b1, 8'h00, 32'h1);
    tick(2);
    chk(ctl.host_secure, 1'b0);
    $display("t_create done");
  endtask : t_create

  task automatic t_modes;
    bus(1'b1, 8'h00, 32'h3);
    press();
    wait_st(32'h20);
    press();
    tick(2);
    chk({ctl.power_en, grn, red}, 32'h0);
    bus(1'b1, 8'h00, 32'h4);
    wait_st(32'h04);
    press();
    chk(ctl.join_traffic_en, 1'b0);
    wait_st(32'h20);
    chk({ctl.host_default_name, ctl.host_secure}, 32'h2);
    press();
    wait_st(32'h04);
    press();
    wait_st(32'h20);
    wait_st(32'h04);
    bus(1'b1, 8'h00, 32'h5);
    press();
    tick(3);
    chk({ctl.power_en, grn, red}, 32'h0);
    $display("t_modes done");
  endtask : t_modes

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    tick(4);
    reset <= 1'b0;
    tick(1);
    t_reset();
    t_offjoin();
    t_join();
    t_create();
    t_modes();
    close_out();
  end
endmodule : wmb_ctrl_tb_top
